// *** gdc_top.sv ***
// Purpose: serial command decoder for four pins and a quad DAC register set
// Assumes: host keeps the serial clock well below a quarter of clock
// Notes: all serial pins are sampled through two flip-flops
// Summary of operation
// - Read returns four zeros then pin states
// - Direction one drives the level bit
// - Direction zero: input, or pulldown when zero
// - Reset command clears DAC registers, power kept
// - Preset command sets DAC registers all ones
// - Codes 2..5 load one input register
// - Codes A,C write through all channels
// - Code D loads all input registers only
// - Code E transfers selected inputs to outputs
// - Power code mode 001 powers up selected
// - Power code modes 000,010,100,111 power down selected; 011,101,110 change nothing
// - Unselected channels keep power state
// - Sixteen-bit word, MSB first, falling edges
// - Command byte 0001xxxx routes next word
// - Short DAC word is discarded
// - Pin registers apply after chip select rise
`timescale 1ns/1ps
module gdc_top (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   sclk,
   input  wire logic                   cs_n,
   input  wire logic                   din,
   output logic                        dout,
   input  wire logic [3:0]             pin_in,
   output logic      [3:0]             pin_out,
   output logic      [3:0]             pin_oe_n,
   output logic      [39:0]            dac_level,
   output gdc_pkg::gdc_buf_type [3:0]  dac_buf_mode
);
   logic [2:0] sync_bus;
   logic [3:0] pin_sync;
   logic       sclk_s;
   logic       cs_n_s;
   logic       din_s;
   gdc_pkg::gdc_pin_drive_type drive;

   gdc_sync #(.WIDTH(7)) u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in ({sclk, cs_n, din, pin_in}),
      .sync_out ({sync_bus, pin_sync})
   );
   assign sclk_s = sync_bus[2];
   assign cs_n_s = sync_bus[1];
   assign din_s  = sync_bus[0];

   typedef enum logic [2:0] {
      GDC_ST_CMD  = 3'b000,
      GDC_ST_CFG  = 3'b001,
      GDC_ST_WR   = 3'b010,
      GDC_ST_RD   = 3'b011,
      GDC_ST_DAC  = 3'b100,
      GDC_ST_SKIP = 3'b101
   } gdc_state_type;

   gdc_state_type state_reg, state_next;
   logic [15:0] shift_reg, shift_next;
   logic [4:0]  cnt_reg, cnt_next;
   logic        sclk_d_reg, sclk_d_next;
   logic        cs_d_reg, cs_d_next;
   logic        dout_reg, dout_next;
   logic [7:0]  rd_reg, rd_next;
   logic [3:0]  cfg_pend_reg, cfg_pend_next;
   logic [3:0]  lvl_pend_reg, lvl_pend_next;
   logic        cfg_dirty_reg, cfg_dirty_next;
   logic        lvl_dirty_reg, lvl_dirty_next;
   logic [3:0]  cfg_reg, cfg_next;
   logic [3:0]  lvl_reg, lvl_next;
   gdc_pkg::gdc_dac_word_type word_reg, word_next;
   logic [9:0]  in_reg   [4];
   logic [9:0]  in_next  [4];
   logic [9:0]  dac_reg  [4];
   logic [9:0]  dac_next [4];
   gdc_pkg::gdc_buf_type buf_reg  [4];
   gdc_pkg::gdc_buf_type buf_next [4];
   logic [2:0]  pwr_mode_reg, pwr_mode_next;
   logic        pwr_go_reg, pwr_go_next;
   logic [3:0]  pwr_sel_reg, pwr_sel_next;

   logic sclk_fall;
   logic sclk_rise;
   logic cs_fall;
   logic cs_rise;
   logic [15:0] shifted;

   assign sclk_fall = sclk_d_reg & ~sclk_s & ~cs_n_s;
   assign sclk_rise = ~sclk_d_reg & sclk_s & ~cs_n_s;
   assign cs_fall   = cs_d_reg & ~cs_n_s;
   assign cs_rise   = ~cs_d_reg & cs_n_s;
   assign shifted   = {shift_reg[14:0], din_s};

   // Serial framing and command decode
   always_comb begin
      state_next    = state_reg;
      shift_next    = shift_reg;
      cnt_next      = cnt_reg;
      sclk_d_next   = sclk_s;
      cs_d_next     = cs_n_s;
      dout_next     = dout_reg;
      rd_next       = rd_reg;
      cfg_pend_next = cfg_pend_reg;
      lvl_pend_next = lvl_pend_reg;
      cfg_dirty_next = cfg_dirty_reg;
      lvl_dirty_next = lvl_dirty_reg;
      cfg_next      = cfg_reg;
      lvl_next      = lvl_reg;
      word_next     = word_reg;
      word_next.valid = 1'b0;
      if (cs_fall) begin
         state_next = GDC_ST_CMD;
         cnt_next   = 5'h00;
         dout_next  = 1'b0;
      end else if (cs_rise) begin
         // Partial words never reach the DAC registers
         state_next = GDC_ST_CMD;
         cnt_next   = 5'h00;
         dout_next  = 1'b0;
         if (cfg_dirty_reg) begin
            cfg_next = cfg_pend_reg;
         end
         if (lvl_dirty_reg) begin
            lvl_next = lvl_pend_reg;
         end
         cfg_dirty_next = 1'b0;
         lvl_dirty_next = 1'b0;
      end else if (sclk_rise && state_reg == GDC_ST_RD) begin
         // Readback shifts out on the edge opposite the sampling edge
         dout_next = rd_reg[7];
         rd_next   = {rd_reg[6:0], 1'b0};
      end else if (sclk_fall) begin
         shift_next = shifted;
         cnt_next   = cnt_reg + 5'h01;
         unique case (state_reg)
            GDC_ST_CMD: begin
               if (cnt_reg == 5'(gdc_pkg::GDC_BYTE_BITS - 1)) begin
                  cnt_next = 5'h00;
                  if (shifted[7:0] == gdc_pkg::GDC_CMD_PIN_CFG) begin
                     state_next = GDC_ST_CFG;
                  end else if (shifted[7:0] == gdc_pkg::GDC_CMD_PIN_WR) begin
                     state_next = GDC_ST_WR;
                  end else if (shifted[7:0] == gdc_pkg::GDC_CMD_PIN_RD) begin
                     state_next = GDC_ST_RD;
                     rd_next    = {4'h0, pin_sync};
                  end else if (shifted[7:4] == gdc_pkg::GDC_CMD_DAC_SEL) begin
                     state_next = GDC_ST_DAC;
                  end else begin
                     state_next = GDC_ST_SKIP;
                  end
               end
            end
            GDC_ST_CFG, GDC_ST_WR: begin
               if (cnt_reg == 5'(gdc_pkg::GDC_BYTE_BITS - 1)) begin
                  state_next = GDC_ST_SKIP;
                  if (state_reg == GDC_ST_CFG) begin
                     cfg_pend_next  = shifted[7:4];
                     cfg_dirty_next = 1'b1;
                  end else begin
                     lvl_pend_next  = shifted[7:4];
                     lvl_dirty_next = 1'b1;
                  end
               end
            end
            GDC_ST_RD: begin
               if (cnt_reg == 5'(gdc_pkg::GDC_BYTE_BITS - 1)) begin
                  state_next = GDC_ST_SKIP;
               end
            end
            GDC_ST_DAC: begin
               if (cnt_reg == 5'(gdc_pkg::GDC_WORD_BITS - 1)) begin
                  state_next = GDC_ST_SKIP;
                  word_next.valid = 1'b1;
                  word_next.ctrl  = shifted[15:12];
                  word_next.data  = shifted[11:2];
               end
            end
            GDC_ST_SKIP: begin
               cnt_next = cnt_reg;
            end
         endcase
      end
   end

   // DAC register file, applied once per complete word
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         in_next[c]  = in_reg[c];
         dac_next[c] = dac_reg[c];
         buf_next[c] = buf_reg[c];
      end
      if (word_reg.valid) begin
         unique case (word_reg.ctrl)
            gdc_pkg::GDC_CTL_RESET: begin
               for (int c = 0; c < 4; c++) begin
                  // Buffer modes stay as they were
                  in_next[c]  = word_reg.data[9] ? gdc_pkg::GDC_DAC_ONES : gdc_pkg::GDC_DAC_ZERO;
                  dac_next[c] = word_reg.data[9] ? gdc_pkg::GDC_DAC_ONES : gdc_pkg::GDC_DAC_ZERO;
               end
            end
            4'h2, 4'h3, 4'h4, 4'h5: begin
               in_next[2'(word_reg.ctrl - gdc_pkg::GDC_CTL_LOAD0)] = word_reg.data;
            end
            gdc_pkg::GDC_CTL_THRU_A, gdc_pkg::GDC_CTL_THRU_B: begin
               for (int c = 0; c < 4; c++) begin
                  in_next[c]  = word_reg.data;
                  dac_next[c] = word_reg.data;
               end
            end
            gdc_pkg::GDC_CTL_LOAD_ALL: begin
               for (int c = 0; c < 4; c++) begin
                  in_next[c] = word_reg.data;
               end
            end
            gdc_pkg::GDC_CTL_XFER: begin
               for (int c = 0; c < 4; c++) begin
                  if (word_reg.data[2 + c]) begin
                     dac_next[c] = in_reg[c];
                  end
               end
            end
            gdc_pkg::GDC_CTL_POWER: begin
               // Buffers follow one clock later from the registered mode
            end
            default: begin
               // Unassigned codes fall through untouched
               in_next[0] = in_reg[0];
            end
         endcase
      end
      for (int c = 0; c < 4; c++) begin
         if (pwr_go_reg && pwr_sel_reg[c]) begin
            unique case (pwr_mode_reg)
               gdc_pkg::GDC_PWR_UP:       buf_next[c] = gdc_pkg::GDC_BUF_ON;
               gdc_pkg::GDC_PWR_HIZ:      buf_next[c] = gdc_pkg::GDC_BUF_HIZ;
               gdc_pkg::GDC_PWR_1K_GND:   buf_next[c] = gdc_pkg::GDC_BUF_1K_GND;
               gdc_pkg::GDC_PWR_100K_GND: buf_next[c] = gdc_pkg::GDC_BUF_100K_GND;
               gdc_pkg::GDC_PWR_100K_REF: buf_next[c] = gdc_pkg::GDC_BUF_100K_REF;
               default:                   buf_next[c] = buf_reg[c];
            endcase
         end
      end
   end
   // Mode decode kept separate: the last mode bit sits below the data field
   always_comb begin
      pwr_go_next   = word_reg.valid && word_reg.ctrl == gdc_pkg::GDC_CTL_POWER;
      pwr_sel_next  = word_reg.data[5:2];
      pwr_mode_next = {word_reg.data[1:0], shift_reg[1]};
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= GDC_ST_CMD;
         shift_reg     <= 16'h0000;
         cnt_reg       <= 5'h00;
         sclk_d_reg    <= 1'b1;
         cs_d_reg      <= 1'b1;
         dout_reg      <= 1'b0;
         rd_reg        <= 8'h00;
         cfg_pend_reg  <= gdc_pkg::GDC_PIN_CFG_RST;
         lvl_pend_reg  <= gdc_pkg::GDC_PIN_LVL_RST;
         cfg_dirty_reg <= 1'b0;
         lvl_dirty_reg <= 1'b0;
         cfg_reg       <= gdc_pkg::GDC_PIN_CFG_RST;
         lvl_reg       <= gdc_pkg::GDC_PIN_LVL_RST;
         word_reg      <= '0;
         pwr_go_reg    <= 1'b0;
         pwr_sel_reg   <= 4'h0;
         pwr_mode_reg  <= 3'h0;
         for (int c = 0; c < 4; c++) begin
            in_reg[c]  <= gdc_pkg::GDC_DAC_ZERO;
            dac_reg[c] <= gdc_pkg::GDC_DAC_ZERO;
            buf_reg[c] <= gdc_pkg::GDC_BUF_ON;
         end
      end else begin
         state_reg     <= state_next;
         shift_reg     <= shift_next;
         cnt_reg       <= cnt_next;
         sclk_d_reg    <= sclk_d_next;
         cs_d_reg      <= cs_d_next;
         dout_reg      <= dout_next;
         rd_reg        <= rd_next;
         cfg_pend_reg  <= cfg_pend_next;
         lvl_pend_reg  <= lvl_pend_next;
         cfg_dirty_reg <= cfg_dirty_next;
         lvl_dirty_reg <= lvl_dirty_next;
         cfg_reg       <= cfg_next;
         lvl_reg       <= lvl_next;
         word_reg      <= word_next;
         pwr_go_reg    <= pwr_go_next;
         pwr_sel_reg   <= pwr_sel_next;
         pwr_mode_reg  <= pwr_mode_next;
         for (int c = 0; c < 4; c++) begin
            in_reg[c]  <= in_next[c];
            dac_reg[c] <= dac_next[c];
            buf_reg[c] <= buf_next[c];
         end
      end
   end

   gdc_pins u_pins (
      .dir_cfg (cfg_reg),
      .out_lvl (lvl_reg),
      .drive   (drive)
   );

   assign dout     = dout_reg;
   assign pin_out  = drive.out;
   assign pin_oe_n = drive.oe_n;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_dac
         assign dac_level[g*10 +: 10] = dac_reg[g];
         assign dac_buf_mode[g]       = buf_reg[g];
      end
   endgenerate

   property p_cfg_hold;
      @(posedge clock) disable iff (!rst_n) !cs_rise |=> cfg_reg == $past(cfg_reg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("pin config changed mid frame");
   property p_drive_out;
      @(posedge clock) disable iff (!rst_n) cfg_reg[0] |-> !pin_oe_n[0] && pin_out[0] == lvl_reg[0];
   endproperty
   a_drive_out: assert property (p_drive_out) else $error("output pin not driving level");
   property p_input_hiz;
      @(posedge clock) disable iff (!rst_n) !cfg_reg[1] && lvl_reg[1] |-> pin_oe_n[1];
   endproperty
   a_input_hiz: assert property (p_input_hiz) else $error("input pin not released");
   property p_word_len;
      @(posedge clock) disable iff (!rst_n) word_reg.valid |-> $past(cnt_reg, 2) == 5'h0F;
   endproperty
   a_word_len: assert property (p_word_len) else $error("DAC word not sixteen bits");
   property p_short_drop;
      @(posedge clock) disable iff (!rst_n) cs_rise |=> !word_reg.valid;
   endproperty
   a_short_drop: assert property (p_short_drop) else $error("short word accepted");
   property p_reset_keeps_buf;
      @(posedge clock) disable iff (!rst_n)
         word_reg.valid && word_reg.ctrl == gdc_pkg::GDC_CTL_RESET |=> buf_reg[0] == $past(buf_reg[0]);
   endproperty
   a_reset_keeps_buf: assert property (p_reset_keeps_buf) else $error("reset changed buffer");
   property p_thru;
      @(posedge clock) disable iff (!rst_n)
         word_reg.valid && word_reg.ctrl == gdc_pkg::GDC_CTL_THRU_A |=> dac_reg[3] == $past(word_reg.data);
   endproperty
   a_thru: assert property (p_thru) else $error("write-through missed");
   property p_load_only;
      @(posedge clock) disable iff (!rst_n)
         word_reg.valid && word_reg.ctrl == gdc_pkg::GDC_CTL_LOAD_ALL |=> dac_reg[0] == $past(dac_reg[0]);
   endproperty
   a_load_only: assert property (p_load_only) else $error("load-all touched output");
   c_dac_word: cover property (@(posedge clock) disable iff (!rst_n) word_reg.valid);
   c_pin_apply: cover property (@(posedge clock) disable iff (!rst_n) cs_rise && cfg_dirty_reg);
   c_power: cover property (@(posedge clock) disable iff (!rst_n) pwr_go_reg);
endmodule

// *** gdc_pkg.sv ***
// Purpose: shared constants and types for the pin and DAC command decoder
// Assumes: serial frames framed by an active-low chip select
// Notes: codes are the command and control encodings of the serial link
package gdc_pkg;
   localparam logic [7:0] GDC_CMD_PIN_CFG   = 8'h03;
   localparam logic [7:0] GDC_CMD_PIN_WR    = 8'h02;
   localparam logic [7:0] GDC_CMD_PIN_RD    = 8'h01;
   localparam logic [3:0] GDC_CMD_DAC_SEL   = 4'h1;
   localparam logic [3:0] GDC_CTL_RESET     = 4'h1;
   localparam logic [3:0] GDC_CTL_LOAD0     = 4'h2;
   localparam logic [3:0] GDC_CTL_LOAD3     = 4'h5;
   localparam logic [3:0] GDC_CTL_THRU_A    = 4'hA;
   localparam logic [3:0] GDC_CTL_THRU_B    = 4'hC;
   localparam logic [3:0] GDC_CTL_LOAD_ALL  = 4'hD;
   localparam logic [3:0] GDC_CTL_XFER      = 4'hE;
   localparam logic [3:0] GDC_CTL_POWER     = 4'hF;
   localparam logic [2:0] GDC_PWR_UP        = 3'h1;
   localparam logic [2:0] GDC_PWR_HIZ       = 3'h2;
   localparam logic [2:0] GDC_PWR_1K_GND    = 3'h4;
   localparam logic [2:0] GDC_PWR_100K_GND  = 3'h0;
   localparam logic [2:0] GDC_PWR_100K_REF  = 3'h7;
   localparam logic [9:0] GDC_DAC_ZERO      = 10'h000;
   localparam logic [9:0] GDC_DAC_ONES      = 10'h3FF;
   localparam logic [3:0] GDC_PIN_CFG_RST   = 4'h0;
   localparam logic [3:0] GDC_PIN_LVL_RST   = 4'hF;
   localparam int         GDC_BYTE_BITS     = 8;
   localparam int         GDC_WORD_BITS     = 16;

   typedef enum logic [2:0] {
      GDC_BUF_ON       = 3'b000,
      GDC_BUF_HIZ      = 3'b001,
      GDC_BUF_1K_GND   = 3'b010,
      GDC_BUF_100K_GND = 3'b011,
      GDC_BUF_100K_REF = 3'b100
   } gdc_buf_type;

   typedef struct packed {
      logic       valid;
      logic [3:0] ctrl;
      logic [9:0] data;
   } gdc_dac_word_type;

   typedef struct packed {
      logic [3:0] oe_n;
      logic [3:0] out;
   } gdc_pin_drive_type;
endpackage

// *** gdc_sync.sv ***
// Purpose: two-flop synchroniser for the serial pins
// Assumes: inputs asynchronous to clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module gdc_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // Reset high: chip select idle; edges are gated by chip select anyway
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '1;
         sync_reg <= '1;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule

// *** gdc_pins.sv ***
// Purpose: drive the four general-purpose pins from direction and level bits
// Assumes: pad resolves level from out and active-low enable
// Notes: bit order c_one, c_zero, a_one, a_zero from 3 down to 0
`timescale 1ns/1ps
module gdc_pins (
   input  wire logic [3:0]               dir_cfg,
   input  wire logic [3:0]               out_lvl,
   output gdc_pkg::gdc_pin_drive_type    drive
);
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_pin
         assign drive.out[i]  = dir_cfg[i] ? out_lvl[i] : 1'b0;
         // Open drain pulldown only when level bit is zero
         assign drive.oe_n[i] = ~(dir_cfg[i] | ~out_lvl[i]);
      end
   endgenerate
endmodule

// *** gdc_host.sv ***
// Purpose: host model that frames serial commands for the decoder
// Assumes: sclk idles low and stands still outside frames
// Notes: every edge comes one ns after a clock rise; half period is four clocks
`timescale 1ns/1ps
module gdc_host (
   input  wire logic clock,
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   input  wire logic dout
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b0;
   end

   // Sends the top n bits of bits; n below the full frame makes a short one
   task automatic frame(input logic [23:0] bits, input int n, output logic [23:0] rx);
      int i;
      rx = '0;
      @(posedge clock);
      #1;
      cs_n = 1'b0;
      for (i = 0; i < n; i++) begin
         repeat (4) @(posedge clock);
         #1;
         din  = bits[23-i];
         sclk = 1'b1;
         repeat (4) @(posedge clock);
         #1;
         // Reply is settled well before the falling edge
         rx   = {rx[22:0], dout};
         sclk = 1'b0;
      end
      repeat (4) @(posedge clock);
      #1;
      cs_n = 1'b1;
      // Released line must not keep its last value
      din  = ~din;
      // Chip select high long enough for the synchroniser and pin update
      repeat (4) @(posedge clock);
   endtask
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the pin and DAC command decoder
// Assumes: design parameters left at their defaults
// Notes: expected DAC state kept in a small model updated per accepted word
`timescale 1ns/1ps
module tb;
   logic                       clock;
   logic                       rst_n;
   logic                       sclk;
   logic                       cs_n;
   logic                       din;
   logic                       dout;
   logic [3:0]                 pin_in;
   logic [3:0]                 pin_out;
   logic [3:0]                 pin_oe_n;
   logic [3:0]                 ext_lvl;
   logic [39:0]                dac_level;
   gdc_pkg::gdc_buf_type [3:0] dac_buf_mode;
   logic [9:0]                 inr [4];
   logic [9:0]                 dr [4];
   gdc_pkg::gdc_buf_type       md [4];
   logic [23:0]                rx;
   int                         errors;
   int                         num_checks;
   int                         cycles;

   // Pad level: our drive where enabled, otherwise the outside world
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);

   gdc_top DUT (.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .dac_level(dac_level),
      .dac_buf_mode(dac_buf_mode));
   gdc_host host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

   initial clock = 1'b0;
   always #20 clock = ~clock;

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check_bits(input string name, input logic [39:0] exp, input logic [39:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_dac();
      int i;
      check_bits("dac_level", {dr[3], dr[2], dr[1], dr[0]}, dac_level);
      for (i = 0; i < 4; i++) begin
         check_bits("dac_buf_mode", 40'(md[i]), 40'(dac_buf_mode[i]));
      end
   endtask

   function automatic gdc_pkg::gdc_buf_type pmode(input logic [2:0] m, input gdc_pkg::gdc_buf_type old);
      case (m)
         3'h1: return gdc_pkg::GDC_BUF_ON;
         3'h2: return gdc_pkg::GDC_BUF_HIZ;
         3'h4: return gdc_pkg::GDC_BUF_1K_GND;
         3'h0: return gdc_pkg::GDC_BUF_100K_GND;
         3'h7: return gdc_pkg::GDC_BUF_100K_REF;
         default: return old;
      endcase
   endfunction

   task automatic apply(input logic [15:0] w);
      int i;
      for (i = 0; i < 4; i++) begin
         case (w[15:12])
            4'h1: begin
               inr[i] = {10{w[11]}};
               dr[i]  = {10{w[11]}};
            end
            4'h2, 4'h3, 4'h4, 4'h5: if (i == int'(w[15:12]) - 2)
               inr[i] = w[11:2];
            4'hA, 4'hC: begin
               inr[i] = w[11:2];
               dr[i]  = w[11:2];
            end
            4'hD: inr[i] = w[11:2];
            4'hE: if (w[4+i])
               dr[i] = inr[i];
            4'hF: if (w[4+i])
               md[i] = pmode(w[3:1], md[i]);
            default: ;
         endcase
      end
   endtask

   task automatic dac_cmd(input logic [15:0] w);
      host.frame({8'h10, w}, 24, rx);
      repeat (8) @(posedge clock);
      apply(w);
   endtask

   task automatic test_reset();
      check_bits("pin_oe_n", 40'h0F, 40'(pin_oe_n));
      check_dac();
   endtask

   task automatic test_pins();
      host.frame({8'h02, 8'hA5, 8'h00}, 16, rx);
      check_bits("dout", 40'h0, 40'(rx[15:0]));
      check_bits("pin_oe_n", 40'h0A, 40'(pin_oe_n));
      host.frame({8'h03, 8'h6F, 8'h00}, 16, rx);
      check_bits("pin_oe_n", 40'h08, 40'(pin_oe_n));
      check_bits("pin_out", 40'h02, 40'(pin_out & ~pin_oe_n));
   endtask

   task automatic test_read();
      ext_lvl = 4'hF;
      host.frame({8'h01, 8'hFF, 8'h00}, 16, rx);
      check_bits("read", 40'h0A, 40'(rx[15:0]));
      ext_lvl = 4'h0;
      host.frame({8'h01, 8'hFF, 8'h00}, 16, rx);
      check_bits("read", 40'h02, 40'(rx[15:0]));
   endtask

   task automatic test_data();
      logic [15:0] seq [9];
      int i;
      seq = '{16'h2044, 16'h3888, 16'h4CCC, 16'h5FFC, 16'hE050, 16'hD554, 16'hA2A8, 16'hE0F0, 16'hC00C};
      for (i = 0; i < 9; i++) begin
         dac_cmd(seq[i]);
         check_dac();
      end
   endtask

   task automatic test_unassigned();
      logic [3:0] codes [6];
      int i;
      codes = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB};
      for (i = 0; i < 6; i++) begin
         dac_cmd({codes[i], 12'h554});
         check_dac();
      end
   endtask

   task automatic test_power();
      logic [15:0] seq [8];
      int i;
      seq = '{16'hF034, 16'hF088, 16'hF040, 16'hF02E, 16'hF016, 16'h1000, 16'h1800, 16'hF0F2};
      for (i = 0; i < 8; i++) begin
         dac_cmd(seq[i]);
         check_dac();
      end
      dac_cmd(16'hF092);
      check_dac();
   endtask

   task automatic test_short();
      host.frame({8'h10, 16'hA2A8}, 20, rx);
      repeat (8) @(posedge clock);
      check_dac();
   endtask

   initial begin
      int i;
      rst_n   = 1'b0;
      ext_lvl = 4'h0;
      for (i = 0; i < 4; i++) begin
         inr[i] = 10'h000;
         dr[i]  = 10'h000;
         md[i]  = gdc_pkg::GDC_BUF_ON;
      end
      repeat (3) @(posedge clock);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge clock);
      test_reset();
      test_pins();
      test_read();
      test_data();
      test_unassigned();
      test_power();
      test_short();
      complete_run();
   end
endmodule
